// ### hdl/lam_mapper.sv
`timescale 1ns/1ns
module lam_mapper #(
  parameter lam_pkg::lam_rate_e RATE = lam_pkg::LAM_RATE_FULL,
  parameter lam_pkg::lam_order_e ORDER =
    lam_pkg::LAM_ORDER_BANK_INTERLEAVE,
  parameter int ROW_BITS = lam_pkg::LAM_ROW_BITS,
  parameter int BANK_BITS = lam_pkg::LAM_BANK_BITS,
  parameter int COL_BITS = lam_pkg::LAM_COL_BITS,
  parameter int NUM_RANKS = lam_pkg::LAM_NUM_RANKS,
  // derived, do not override
  parameter int CHIP_BITS = (NUM_RANKS > 1) ? $clog2(NUM_RANKS) : 0,
  parameter int DROP = lam_pkg::lam_drop(RATE),
  parameter int ADDR_W = CHIP_BITS + ROW_BITS + BANK_BITS + COL_BITS
    - DROP,
  parameter int CHIP_W = (CHIP_BITS > 0) ? CHIP_BITS : 1
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // user reset and config clock
  output logic user_reset_n,
  output logic csr_clk,
  // burst request from the bus master
  input wire logic req_valid,
  input wire logic burst_begin,
  input wire logic [ADDR_W-1:0] burst_addr,
  output logic req_ready,
  // slave property
  output logic fixed_burst_behavior_property,
  // memory-side fields of the captured burst
  output logic map_valid,
  output logic [CHIP_W-1:0] mem_chip,
  output logic [ROW_BITS-1:0] mem_row,
  output logic [BANK_BITS-1:0] mem_bank,
  output logic [COL_BITS-1:0] mem_col
);

  // width of the column part carried in the address
  localparam int CW = COL_BITS - DROP;

  // all state in one word
  typedef struct packed {
    lam_pkg::lam_state_e st;
    logic valid;
    logic [CHIP_W-1:0] chip;
    logic [ROW_BITS-1:0] row;
    logic [BANK_BITS-1:0] bank;
    logic [COL_BITS-1:0] col;
  } lam_state_s;

  lam_state_s state_reg; // registered state
  lam_state_s state_next; // next value

  // address widened by one zero bit above the top
  logic [ADDR_W:0] ext_addr;
  // decoded fields of the incoming address
  logic [CHIP_W-1:0] dec_chip;
  logic [ROW_BITS-1:0] dec_row;
  logic [BANK_BITS-1:0] dec_bank;
  logic [COL_BITS-1:0] dec_col;
  // start of burst accepted this cycle
  logic take;

  // sizing is fixed by the rate: minus one, two or three
  initial begin
    if (ADDR_W != CHIP_BITS + ROW_BITS + BANK_BITS + COL_BITS
        - DROP) begin
      $error("lam_mapper address width mismatch");
    end
  end

  // extra zero bit lets a single-rank build read chip as zero
  assign ext_addr = {1'b0, burst_addr};

  // chip bits always sit on top, derived width only
  assign dec_chip = ext_addr[ADDR_W-CHIP_BITS +: CHIP_W];

  // the low column bits come from nowhere: word spans them
  assign dec_col = {burst_addr[CW-1:0], {DROP{1'b0}}};

  // field split by build-time ordering
  generate
    if (ORDER == lam_pkg::LAM_ORDER_BANK_INTERLEAVE) begin : g_intl
      // row highest, then bank, then column
      assign dec_bank = burst_addr[CW +: BANK_BITS];
      assign dec_row = burst_addr[CW+BANK_BITS +: ROW_BITS];
    end else begin : g_brc
      // bank highest, then row, then column
      assign dec_row = burst_addr[CW +: ROW_BITS];
      assign dec_bank = burst_addr[CW+ROW_BITS +: BANK_BITS];
    end
  endgenerate

  // never promise a constant address over a burst
  assign fixed_burst_behavior_property = lam_pkg::LAM_FIXED_BURST;

  // config clock is the user clock itself, no crossing
  assign csr_clk = clk;

  // reset asserts with no clock, releases through the sequencer
  assign user_reset_n = !reset &&
    (state_reg.st == lam_pkg::LAM_ST_RUN);

  // ready once out of reset; no internal stall exists
  assign req_ready = user_reset_n;

  // a burst starts only on its first beat
  assign take = ce && user_reset_n && req_valid && burst_begin;

  // next state
  always_comb begin
    state_next = state_reg;
    // valid is a one-beat pulse
    state_next.valid = 1'b0;
    case (state_reg.st)
      lam_pkg::LAM_ST_HOLD: begin
        // leave hold on the first clean edge
        state_next.st = lam_pkg::LAM_ST_RUN;
      end
      lam_pkg::LAM_ST_RUN: begin
        // capture fields; later beats are not looked at
        if (take) begin
          state_next.valid = 1'b1;
          state_next.chip = dec_chip;
          state_next.row = dec_row;
          state_next.bank = dec_bank;
          state_next.col = dec_col;
        end
      end
      default: begin
        // unreachable encoding, go back to hold
        state_next.st = lam_pkg::LAM_ST_HOLD;
      end
    endcase
  end

  // register, synchronous reset, enable freezes all state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg.st <= lam_pkg::LAM_ST_HOLD;
      state_reg.valid <= lam_pkg::LAM_VALID_RST;
      state_reg.chip <= '0;
      state_reg.row <= '0;
      state_reg.bank <= '0;
      state_reg.col <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops
  assign map_valid = state_reg.valid;
  assign mem_chip = state_reg.chip;
  assign mem_row = state_reg.row;
  assign mem_bank = state_reg.bank;
  assign mem_col = state_reg.col;

  // checks share one clock and, except chk_reset_assert, the sync reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // width equation per rate holds for every build
  chk_addr_width: assert property (
    ADDR_W + DROP == CHIP_BITS + ROW_BITS + BANK_BITS + COL_BITS
    && DROP == int'(RATE) + 1)
    else $error("address width does not fit the rate");

  // chip field width comes from rank count
  chk_chip_width: assert property (
    (NUM_RANKS > 1) ? (CHIP_BITS == $clog2(NUM_RANKS))
      : (mem_chip == '0))
    else $error("chip field width or value wrong");

  // low column bits stay zero at every cycle
  chk_col_low_zero: assert property (
    mem_col[DROP-1:0] == '0)
    else $error("dropped column bits are driven");

  // column upper bits equal the address low bits
  chk_col_map: assert property (
    take |=> mem_col[COL_BITS-1:DROP] == $past(burst_addr[CW-1:0]))
    else $error("column field mapped wrong");

  // row and bank follow the chosen ordering
  chk_row_bank_order: assert property (
    take |=> (ORDER == lam_pkg::LAM_ORDER_BANK_INTERLEAVE)
      ? (mem_bank == $past(burst_addr[CW +: BANK_BITS]) &&
         mem_row == $past(burst_addr[CW+BANK_BITS +: ROW_BITS]))
      : (mem_row == $past(burst_addr[CW +: ROW_BITS]) &&
         mem_bank == $past(burst_addr[CW+ROW_BITS +: BANK_BITS])))
    else $error("row or bank field mapped wrong");

  // fields hold until the next first beat
  chk_hold_capture: assert property (
    !take && ce |=> $stable(mem_row) && $stable(mem_bank)
      && $stable(mem_col) && !map_valid)
    else $error("fields moved without a new burst");

  // valid pulse always follows an accepted first beat
  chk_valid_cause: assert property (
    ce && map_valid |-> $past(take))
    else $error("map valid without a burst start");

  // slave never claims constant burst behaviour
  chk_fixed_burst: assert property (
    fixed_burst_behavior_property == 1'b0 && csr_clk == clk)
    else $error("constant burst property must read zero");

  // user reset low in the cycle reset is high
  chk_reset_assert: assert property (
    @(posedge clk) disable iff (1'b0)
    reset |-> !user_reset_n && !req_ready)
    else $error("user reset not asserted with reset");

  // release comes one enabled edge after reset falls
  chk_reset_release: assert property (
    !user_reset_n && ce |=> user_reset_n)
    else $error("user reset release late");

  // ready tracks the user reset, no hidden stall source
  chk_ready_follow: assert property (
    req_ready == user_reset_n)
    else $error("ready differs from user reset");

endmodule // lam_mapper

// ### hdl/lam_pkg.sv
// How it works
// - full rate width is fields minus one
// - full rate 24-bit row, bank, column split
// - full rate column bit zero never driven
// - half rate width is fields minus two
// - half rate 23-bit row, bank, column split
// - half rate column bits one, zero undriven
// - quarter rate width is fields minus three
// - chip width derived from rank count only
// - declare burst address need not stay constant
// - bank interleave default, other order selectable
// - config clock is the same user clock
// - all user signals on user clock
// - user reset asserts async, releases synchronously
package lam_pkg;

  // controller rate against the memory clock
  typedef enum logic [1:0] {
    LAM_RATE_FULL,
    LAM_RATE_HALF,
    LAM_RATE_QUARTER
  } lam_rate_e;

  // ordering of fields inside the local address
  typedef enum logic {
    LAM_ORDER_BANK_INTERLEAVE,
    LAM_ORDER_BANK_ROW_COL
  } lam_order_e;

  // reset-release sequencer
  typedef enum logic {
    LAM_ST_HOLD,
    LAM_ST_RUN
  } lam_state_e;

  // documented example geometry
  localparam int LAM_ROW_BITS = 13;
  localparam int LAM_BANK_BITS = 2;
  localparam int LAM_COL_BITS = 10;
  localparam int LAM_NUM_RANKS = 1;

  // low column bits dropped per rate
  localparam int LAM_DROP_FULL = 1;
  localparam int LAM_DROP_HALF = 2;
  localparam int LAM_DROP_QUARTER = 3;

  // the burst address must not be assumed constant
  localparam logic LAM_FIXED_BURST = 1'b0;

  // value of the valid flag after reset
  localparam logic LAM_VALID_RST = 1'b0;

  // column bits that one local word spans
  function automatic int lam_drop(input lam_rate_e rate);
    case (rate)
      LAM_RATE_FULL: lam_drop = LAM_DROP_FULL;
      LAM_RATE_HALF: lam_drop = LAM_DROP_HALF;
      default: lam_drop = LAM_DROP_QUARTER;
    endcase
  endfunction

endpackage

// ### testbench/lam_master_model.sv
`timescale 1ns/1ns
module lam_master_model (
  // clock and handshake
  input wire logic clk,
  input wire logic req_ready,
  // request towards the mapper
  output logic req_valid,
  output logic burst_begin,
  output logic [23:0] burst_addr
);
  // idle until the first burst
  initial begin
    req_valid = 1'b0;
    burst_begin = 1'b0;
    burst_addr = 24'h000000;
  end

  // one two-beat burst; first marks whether the opening beat is flagged
  task automatic burst(input logic [23:0] a, input logic first);
    @(posedge clk);
    req_valid <= 1'b1;
    burst_begin <= first;
    burst_addr <= a;
    // hold everything until the mapper is ready
    @(posedge clk);
    while (req_ready !== 1'b1) @(posedge clk);
    // second beat: flag dropped, address scrambled, not held
    burst_begin <= 1'b0;
    burst_addr <= ~a;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
endmodule // lam_master_model

// ### testbench/local_address_mapper_bench.sv
`timescale 1ns/1ns
module local_address_mapper_bench;
  // shared stimulus
  logic clk, reset, ce, req_valid, burst_begin;
  logic [23:0] burst_addr;
  // per-rate outputs: 0 full, 1 half, 2 quarter
  logic urn [3], csr [3], rdy [3], fbp [3], mv [3], chip [3];
  logic [12:0] row [3];
  logic [1:0] bank [3];
  logic [9:0] col [3];
  int n_fail, n_tests, pulses [3];
  // outputs of the alternate-order build, full rate
  logic [12:0] alt_row;
  logic [1:0] alt_bank;
  logic [9:0] alt_col;
  // address patterns, lowest bit alone and all ones included
  logic [23:0] pats [4] = '{24'hABCDEF, 24'h000001, 24'hFFFFFF, 24'h5A5A5A};

  // one mapper per rate, each sees the low address bits it is sized for
  for (genvar i = 0; i < 3; i++) begin : g
    lam_mapper #(.RATE(lam_pkg::lam_rate_e'(i))) lam_mapper_inst (
      .clk(clk), .reset(reset), .ce(ce), .user_reset_n(urn[i]),
      .csr_clk(csr[i]), .req_valid(req_valid), .burst_begin(burst_begin),
      .burst_addr(burst_addr[23-i:0]), .req_ready(rdy[i]),
      .fixed_burst_behavior_property(fbp[i]), .map_valid(mv[i]),
      .mem_chip(chip[i]), .mem_row(row[i]), .mem_bank(bank[i]),
      .mem_col(col[i]));
  end

  // bank-above-row ordering, full rate, fields only
  lam_mapper #(.ORDER(lam_pkg::LAM_ORDER_BANK_ROW_COL)) lam_mapper_inst (
    .clk(clk), .reset(reset), .ce(ce), .user_reset_n(), .csr_clk(),
    .req_valid(req_valid), .burst_begin(burst_begin),
    .burst_addr(burst_addr), .req_ready(),
    .fixed_burst_behavior_property(), .map_valid(), .mem_chip(),
    .mem_row(alt_row), .mem_bank(alt_bank), .mem_col(alt_col));

  // bus master on the far side
  lam_master_model lam_master_model_inst (
    .clk(clk), .req_ready(rdy[0]), .req_valid(req_valid),
    .burst_begin(burst_begin), .burst_addr(burst_addr));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // count valid pulses; a stretched pulse shows up as an extra count
  always @(posedge clk)
    for (int i = 0; i < 3; i++) if (mv[i] === 1'b1) pulses[i]++;

  // single comparison point
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // expected fields of every rate for address a
  task automatic fields(input logic [23:0] a, input int np);
    int d;
    for (int i = 0; i < 3; i++) begin
      d = i + 1;
      check(pulses[i], np);
      check(col[i], (a << d) & 24'h3FF);
      check(bank[i], (a >> (10 - d)) & 24'h3);
      check(row[i], (a >> (12 - d)) & 24'h1FFF);
      check(chip[i], 24'h0);
    end
    check(alt_col, (a << 1) & 24'h3FF);
    check(alt_row, (a >> 9) & 24'h1FFF);
    check(alt_bank, (a >> 22) & 24'h3);
  endtask

  // quiet outputs in reset, release one edge late
  task automatic t_reset;
    repeat (12) @(negedge clk);
    for (int i = 0; i < 3; i++) begin
      check({urn[i], rdy[i], mv[i], row[i]}, 24'h0);
      check(fbp[i], 24'h0);
    end
    @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(urn[0], 24'h0);
    @(negedge clk);
    for (int i = 0; i < 3; i++) begin
      check({urn[i], rdy[i]}, 24'h3);
      check(csr[i], clk);
    end
    $display("t_reset done");
  endtask

  // each pattern through all three rates
  task automatic t_map;
    foreach (pats[k]) begin
      lam_master_model_inst.burst(pats[k], 1'b1);
      @(negedge clk);
      fields(pats[k], k + 1);
    end
    $display("t_map done");
  endtask

  // unflagged beats and disabled clock take nothing
  task automatic t_refuse;
    lam_master_model_inst.burst(24'h123456, 1'b0);
    ce <= 1'b0;
    lam_master_model_inst.burst(24'h654321, 1'b1);
    ce <= 1'b1;
    @(negedge clk);
    fields(pats[3], 4);
    $display("t_refuse done");
  endtask

  // mid-run reset drops user reset at once, not at the edge
  task automatic t_reset2;
    @(posedge clk);
    reset <= 1'b1;
    #1;
    check(urn[1], 24'h0);
    @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check({urn[2], row[2]}, 24'h0);
    @(negedge clk);
    check(urn[2], 24'h1);
    $display("t_reset2 done");
  endtask

  // counts and verdict
  task automatic tally_and_finish;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog at 2000 cycles, far beyond the few dozen cycles the tests need
  initial begin
    #100000;
    n_fail++;
    $display("unexpected at %0t: timeout", $time);
    tally_and_finish;
  end

  // main sequence
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    t_reset;
    t_map;
    t_refuse;
    t_reset2;
    tally_and_finish;
  end
endmodule // local_address_mapper_bench
